//--- hdl/rnc_top.sv
// random number unit: apb registers, seed load and lfsr generator
// Functional notes
// - identification word holds 16-bit id, 8-bit version, 8-bit revision.
// - setting control bit 12 copies true seed into generator, then self-clears.
// - control bit 11 picks bias corrector when set, xor tree when clear.
// - bit 10 set shifts every cycle; clear shifts after value is taken.
// - pseudo generator runs only while control bit 9 is set.
// - true random source runs only while control bit 8 is set.
// - polynomial length in bits comes from control bits 7 to 0.
// - control bits 31 to 13 read zero and ignore writes.
// - 64-bit polynomial sits in two words, low half first.
// - seed load moves both captured seed words into both output words.
// - reverse-shift lfsr, top tap at bit 0, length sets feedback point.
`timescale 1ns/1ps
module rnc_top (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           reset,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // ring oscillator samples
  input  wire logic [rnc_pkg::RING_COUNT-1:0] ringRaw
);
  localparam int W = rnc_pkg::LFSR_WIDTH;

  logic [rnc_pkg::CTRL_STORED_MSB:0] ctrl_reg;
  logic [rnc_pkg::CTRL_STORED_MSB:0] ctrl_next;
  logic                              load_reg;
  logic                              load_next;
  logic [W-1:0]                      feedback_taps_reg;
  logic [W-1:0]                      feedback_taps_next;
  logic [W-1:0]                      state_reg;
  logic [W-1:0]                      state_next;
  logic                              taken_reg;
  logic                              taken_next;
  logic [31:0]                       rdata_reg;
  logic [31:0]                       rdata_next;

  logic [rnc_pkg::RING_COUNT-1:0]    ringBits;
  logic [W-1:0]                      seedWord;
  logic                              setup;
  logic                              access;
  logic                              wrEn;
  logic                              rdLoDone;
  logic                              advance;
  logic [W-1:0]                      lenMask;
  logic [7:0]                        effLen;
  logic                              feedback;

  // decoders used by write and error paths
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = a <= rnc_pkg::ADDR_SEED_HI && a[1:0] == 2'b00;
  endfunction

  function automatic logic isWritable(input logic [11:0] a);
    isWritable = a == rnc_pkg::ADDR_CTRL || a == rnc_pkg::ADDR_FEEDBACK_TAPS_LO
              || a == rnc_pkg::ADDR_FEEDBACK_TAPS_HI || a == rnc_pkg::ADDR_OUT_LO
              || a == rnc_pkg::ADDR_OUT_HI;
  endfunction

  // length 0 or above the register width falls back to full width
  function automatic logic [7:0] clampLen(input logic [7:0] len);
    if (len == 8'h00 || len > rnc_pkg::LFSR_MAXLEN) begin
      clampLen = rnc_pkg::LFSR_MAXLEN;
    end else begin
      clampLen = len;
    end
  endfunction

  rnc_sync #(
    .WIDTH (rnc_pkg::RING_COUNT)
  ) u_sync (
    .clock  (clock),
    .reset  (reset),
    .async  (ringRaw),
    .synced (ringBits)
  );

  rnc_entropy u_entropy (
    .clock        (clock),
    .reset        (reset),
    .enable       (ctrl_reg[rnc_pkg::CTRL_TRUE_EN]),
    .useCorrector (ctrl_reg[rnc_pkg::CTRL_CONDITION]),
    .ringBits     (ringBits),
    .seedWord     (seedWord)
  );

  // bus phases; no wait states, so every access completes
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wrEn     = access && pwrite && isWritable(paddr);
  assign rdLoDone = access && !pwrite && paddr == rnc_pkg::ADDR_OUT_LO;
  assign pready   = 1'b1;
  assign pslverr  = access && (!isMapped(paddr) || (pwrite && !isWritable(paddr)));
  assign prdata   = rdata_reg;

  // read data registered in the setup cycle, presented in access
  always_comb begin
    rdata_next = rdata_reg;
    if (setup) begin
      case (paddr)
        rnc_pkg::ADDR_IDENT: begin
          rdata_next = {rnc_pkg::IDENT_BLOCK, rnc_pkg::IDENT_VERSION,
                        rnc_pkg::IDENT_REVISION};
        end
        rnc_pkg::ADDR_CTRL: begin
          rdata_next = {{rnc_pkg::CTRL_ZERO_WIDTH{1'b0}}, load_reg, ctrl_reg};
        end
        rnc_pkg::ADDR_FEEDBACK_TAPS_LO: rdata_next = feedback_taps_reg[31:0];
        rnc_pkg::ADDR_FEEDBACK_TAPS_HI: rdata_next = feedback_taps_reg[W-1:32];
        rnc_pkg::ADDR_OUT_LO:  rdata_next = state_reg[31:0];
        rnc_pkg::ADDR_OUT_HI:  rdata_next = state_reg[W-1:32];
        rnc_pkg::ADDR_SEED_LO: rdata_next = seedWord[31:0];
        rnc_pkg::ADDR_SEED_HI: rdata_next = seedWord[W-1:32];
        default:               rdata_next = 32'h0;
      endcase
    end
  end

  // control word and seed load request
  always_comb begin
    ctrl_next = ctrl_reg;
    load_next = 1'b0;
    if (wrEn && paddr == rnc_pkg::ADDR_CTRL) begin
      // upper bits are dropped here
      ctrl_next = pwdata[rnc_pkg::CTRL_STORED_MSB:0];
      load_next = pwdata[rnc_pkg::CTRL_SEED_LOAD];
    end
  end

  // polynomial words
  always_comb begin
    feedback_taps_next = feedback_taps_reg;
    if (wrEn && paddr == rnc_pkg::ADDR_FEEDBACK_TAPS_LO) begin
      feedback_taps_next[31:0] = pwdata;
    end
    if (wrEn && paddr == rnc_pkg::ADDR_FEEDBACK_TAPS_HI) begin
      feedback_taps_next[W-1:32] = pwdata;
    end
  end

  // lfsr feedback: tap bit i stands for x^(len-i)
  always_comb begin
    effLen   = clampLen(ctrl_reg[rnc_pkg::CTRL_LEN_MSB:0]);
    lenMask  = {W{1'b1}} >> (8'(W) - effLen);
    feedback = ^(state_reg & feedback_taps_reg & lenMask);
  end

  // shift policy; taken flag remembers a read not yet consumed
  always_comb begin
    advance = ctrl_reg[rnc_pkg::CTRL_PSEUDO_EN]
           && (ctrl_reg[rnc_pkg::CTRL_SHIFT_EVERY] || taken_reg);
    taken_next = taken_reg;
    if (advance || ctrl_reg[rnc_pkg::CTRL_SHIFT_EVERY]) begin
      taken_next = 1'b0;
    end
    if (rdLoDone && !ctrl_reg[rnc_pkg::CTRL_SHIFT_EVERY]) begin
      taken_next = 1'b1;
    end
  end

  // generator state: bus write, then seed load, then shift
  always_comb begin
    state_next = state_reg;
    if (load_reg) begin
      state_next = seedWord;
    end else if (advance) begin
      state_next = ((state_reg >> 1) & lenMask)
                 | ({{(W-1){1'b0}}, feedback} << (effLen - 8'h01));
    end
    if (wrEn && paddr == rnc_pkg::ADDR_OUT_LO) begin
      state_next[31:0] = pwdata;
    end
    if (wrEn && paddr == rnc_pkg::ADDR_OUT_HI) begin
      state_next[W-1:32] = pwdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg  <= rnc_pkg::CTRL_RESET;
      load_reg  <= 1'b0;
      feedback_taps_reg  <= {rnc_pkg::FEEDBACK_TAPS_RESET, rnc_pkg::FEEDBACK_TAPS_RESET};
      state_reg <= {rnc_pkg::OUT_RESET, rnc_pkg::OUT_RESET};
      taken_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      load_reg  <= load_next;
      feedback_taps_reg  <= feedback_taps_next;
      state_reg <= state_next;
      taken_reg <= taken_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule // rnc_top

//--- inc/rnc_pkg.sv
// constants and types shared by the random number control block
package rnc_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_IDENT   = 12'h000;
  localparam logic [11:0] ADDR_CTRL    = 12'h004;
  localparam logic [11:0] ADDR_FEEDBACK_TAPS_LO = 12'h008;
  localparam logic [11:0] ADDR_FEEDBACK_TAPS_HI = 12'h00c;
  localparam logic [11:0] ADDR_OUT_LO  = 12'h010;
  localparam logic [11:0] ADDR_OUT_HI  = 12'h014;
  localparam logic [11:0] ADDR_SEED_LO = 12'h018;
  localparam logic [11:0] ADDR_SEED_HI = 12'h01c;

  // identification fields, values arbitrary
  localparam logic [15:0] IDENT_BLOCK    = 16'h5a5a;
  localparam logic [7:0]  IDENT_VERSION  = 8'h01;
  localparam logic [7:0]  IDENT_REVISION = 8'h00;
  localparam int          IDENT_BLOCK_LSB   = 16;
  localparam int          IDENT_VERSION_LSB = 8;

  // control word field positions
  localparam int CTRL_SEED_LOAD   = 12;
  localparam int CTRL_CONDITION   = 11;
  localparam int CTRL_SHIFT_EVERY = 10;
  localparam int CTRL_PSEUDO_EN   = 9;
  localparam int CTRL_TRUE_EN     = 8;
  localparam int CTRL_LEN_MSB     = 7;
  localparam int CTRL_STORED_MSB  = 11;
  localparam int CTRL_ZERO_WIDTH  = 19;

  // reset values
  localparam logic [11:0] CTRL_RESET    = 12'h064;
  localparam logic [31:0] FEEDBACK_TAPS_RESET    = 32'hffff0000;
  localparam logic [31:0] OUT_RESET     = 32'hffffffff;
  localparam logic [63:0] SEED_RESET    = 64'h0;

  // generator geometry
  localparam int          LFSR_WIDTH = 64;
  localparam logic [7:0]  LFSR_MAXLEN = 8'h40;
  localparam int          RING_COUNT = 4;
  localparam int          SYNC_STAGES = 2;

  // bias corrector pairing states
  typedef enum logic [1:0] {
    PAIR_FIRST  = 2'b01,
    PAIR_SECOND = 2'b10
  } rnc_pair_e;
endpackage

//--- hdl/rnc_sync.sv
// two-flop synchroniser for the ring oscillator samples
`timescale 1ns/1ps
module rnc_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage is read only by the second
  always_comb begin
    meta_next = async;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign synced = sync_reg;
endmodule // rnc_sync

//--- hdl/rnc_entropy.sv
// entropy conditioning and seed capture for the true random source
`timescale 1ns/1ps
module rnc_entropy (
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            reset,
  // control
  input  wire logic                            enable,
  input  wire logic                            useCorrector,
  // synchronised ring samples
  input  wire logic [rnc_pkg::RING_COUNT-1:0]  ringBits,
  // captured seed
  output logic      [rnc_pkg::LFSR_WIDTH-1:0]  seedWord
);
  rnc_pkg::rnc_pair_e               pair_reg;
  rnc_pkg::rnc_pair_e               pair_next;
  logic                             first_reg;
  logic                             first_next;
  logic [rnc_pkg::LFSR_WIDTH-1:0]   seed_reg;
  logic [rnc_pkg::LFSR_WIDTH-1:0]   seed_next;
  logic                             bitValid;
  logic                             bitValue;

  always_comb begin
    pair_next  = pair_reg;
    first_next = first_reg;
    seed_next  = seed_reg;
    bitValid   = 1'b0;
    bitValue   = ^ringBits;
    if (enable) begin
      if (useCorrector) begin
        // unequal pairs only; removes bias at the cost of throughput
        case (pair_reg)
          rnc_pkg::PAIR_FIRST: begin
            first_next = ringBits[0];
            pair_next  = rnc_pkg::PAIR_SECOND;
          end
          rnc_pkg::PAIR_SECOND: begin
            bitValid  = first_reg != ringBits[0];
            bitValue  = first_reg;
            pair_next = rnc_pkg::PAIR_FIRST;
          end
          default: pair_next = rnc_pkg::PAIR_FIRST;
        endcase
      end else begin
        bitValid  = 1'b1;
        pair_next = rnc_pkg::PAIR_FIRST;
      end
      if (bitValid) begin
        seed_next = {seed_reg[rnc_pkg::LFSR_WIDTH-2:0], bitValue};
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pair_reg  <= rnc_pkg::PAIR_FIRST;
      first_reg <= 1'b0;
      seed_reg  <= rnc_pkg::SEED_RESET;
    end else begin
      pair_reg  <= pair_next;
      first_reg <= first_next;
      seed_reg  <= seed_next;
    end
  end

  assign seedWord = seed_reg;
endmodule // rnc_entropy

//--- test/rnc_top_monitor.sv
// assertion checker for the random number control block
`timescale 1ns/1ps
module rnc_top_monitor (
  // clock and reset
  input wire logic                           clock,
  input wire logic                           reset,
  // apb slave
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [11:0]                    paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // ring samples
  input wire logic [rnc_pkg::RING_COUNT-1:0] ringRaw
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic        acc;
  logic        wrCtrl;
  logic [31:0] polySeen_reg;
  logic [31:0] polySeen_next;
  logic [11:0] ctrlSeen_reg;
  logic [11:0] ctrlSeen_next;
  assign acc = psel && penable;
  assign wrCtrl = acc && pwrite && paddr == rnc_pkg::ADDR_CTRL;
  // shadow of what software last wrote, to judge read-back
  always_comb begin
    polySeen_next = polySeen_reg;
    ctrlSeen_next = ctrlSeen_reg;
    if (acc && pwrite && paddr == rnc_pkg::ADDR_FEEDBACK_TAPS_LO) begin
      polySeen_next = pwdata;
    end
    if (wrCtrl) begin
      ctrlSeen_next = pwdata[11:0];
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      polySeen_reg <= rnc_pkg::FEEDBACK_TAPS_RESET;
      ctrlSeen_reg <= rnc_pkg::CTRL_RESET;
    end else begin
      polySeen_reg <= polySeen_next;
      ctrlSeen_reg <= ctrlSeen_next;
    end
  end
  sequence ctrl_rd;
    psel && !penable && !pwrite && paddr == rnc_pkg::ADDR_CTRL ##1 acc;
  endsequence
  ident_value_a: assert property (acc && !pwrite && paddr == rnc_pkg::ADDR_IDENT |->
    prdata == {rnc_pkg::IDENT_BLOCK, rnc_pkg::IDENT_VERSION, rnc_pkg::IDENT_REVISION})
    else $error("identification word wrong");
  ident_wr_err_a: assert property (acc && pwrite && paddr == 12'h000 |-> pslverr)
    else $error("identification write not refused");
  ctrl_zero_a: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[31:13] == 0)
    else $error("control upper bits not zero");
  load_clear_a: assert property (!wrCtrl ##1 ctrl_rd |-> !prdata[12])
    else $error("seed load bit did not clear");
  ctrl_back_a: assert property (acc && !pwrite && paddr == 12'h004 |->
    prdata[11:0] == ctrlSeen_reg) else $error("control read-back wrong");
  feedback_taps_back_a: assert property (acc && !pwrite && paddr == 12'h008 |->
    prdata == polySeen_reg) else $error("polynomial read-back wrong");
  seed_ro_a: assert property (acc && pwrite && paddr[11:3] == 9'h003 |-> pslverr)
    else $error("seed write not refused");
  out_wr_ok_a: assert property (acc && pwrite && paddr == 12'h010 |-> pready && !pslverr)
    else $error("output word write refused");
  unmapped_a: assert property (acc && (paddr > 12'h01c || paddr[1:0] != 0) |->
    pslverr && prdata == 0) else $error("unmapped access not refused");
endmodule // rnc_top_monitor

//--- test/rnc_top_test.sv
// self-checking bench for the random number control block
`timescale 1ns/1ps
module rnc_top_test;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ringRaw = 4'h1;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          tset;
  logic [31:0] rd;
  logic        err;
  rnc_top u_rnc_top (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ringRaw(ringRaw));
  always #2 clock = ~clock;
  // small lfsr on the rings so the corrector sees unequal pairs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ringRaw <= {ringRaw[2:0], ringRaw[3] ^ ringRaw[2]};
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    tset = cyc;
    penable <= 1'b1;
    // no local limit: only the watchdog may end a stuck access
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  function automatic logic [63:0] step(logic [63:0] s, logic [63:0] p, int n);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    return ((s >> 1) & m) | (64'(^(s & p & m)) << (n - 1));
  endfunction
  task automatic t_reset();
    logic [31:0] e[8];
    e = '{{rnc_pkg::IDENT_BLOCK, rnc_pkg::IDENT_VERSION, rnc_pkg::IDENT_REVISION},
      32'h64, 32'hffff0000, 32'hffff0000, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rdchk(12'(i * 4), e[i]);
    end
  endtask
  task automatic t_access();
    xfer(1'b1, 12'h004, 32'hffffe0ff);
    rdchk(12'h004, 32'h000000ff);
    xfer(1'b1, 12'h000, 32'h0);
    check(32'(err), 32'h1);
    xfer(1'b1, 12'h018, 32'h1234);
    check(32'(err), 32'h1);
    rdchk(12'h018, 32'h0);
    rdchk(12'h020, 32'h0);
    check(32'(err), 32'h1);
    xfer(1'b1, 12'h008, 32'ha5a55a5a);
    xfer(1'b1, 12'h00c, 32'h0f0f1e1e);
    rdchk(12'h008, 32'ha5a55a5a);
    rdchk(12'h00c, 32'h0f0f1e1e);
  endtask
  task automatic t_lfsr();
    logic [63:0] s;
    s = {32'hffffffff, 32'h5d};
    xfer(1'b1, 12'h008, 32'hb8);
    xfer(1'b1, 12'h00c, 32'h0);
    xfer(1'b1, 12'h010, 32'h5d);
    xfer(1'b1, 12'h004, 32'h208);
    // low word read during reset checks left a removal pending; it shifts once now
    s = step(s, 64'hb8, 8);
    for (int i = 0; i < 4; i++) begin
      rdchk(12'h010, s[31:0]);
      s = step(s, 64'hb8, 8);
    end
    xfer(1'b1, 12'h004, 32'h008);
    rdchk(12'h010, s[31:0]);
    rdchk(12'h010, s[31:0]);
  endtask
  task automatic t_shift_every_cycle();
    logic [63:0] s;
    int t1;
    xfer(1'b1, 12'h004, 32'h608);
    xfer(1'b0, 12'h010, 32'h0);
    s = {32'h0, rd};
    t1 = tset;
    xfer(1'b0, 12'h010, 32'h0);
    for (int i = t1; i < tset; i++) begin
      s = step(s, 64'hb8, 8);
    end
    check(rd, s[31:0]);
  endtask
  task automatic t_seed();
    logic [31:0] lo;
    logic [31:0] hi;
    xfer(1'b1, 12'h004, 32'h108);
    repeat (100) @(posedge clock);
    xfer(1'b1, 12'h004, 32'h008);
    xfer(1'b0, 12'h018, 32'h0);
    lo = rd;
    xfer(1'b0, 12'h01c, 32'h0);
    hi = rd;
    check(32'(|{lo, hi}), 32'h1);
    repeat (50) @(posedge clock);
    rdchk(12'h018, lo);
    xfer(1'b1, 12'h004, 32'h1008);
    rdchk(12'h010, lo);
    rdchk(12'h014, hi);
    rdchk(12'h004, 32'h008);
    xfer(1'b1, 12'h004, 32'h908);
    repeat (200) @(posedge clock);
    xfer(1'b1, 12'h004, 32'h008);
    xfer(1'b0, 12'h018, 32'h0);
    check(32'(rd != lo), 32'h1);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_access();
    t_lfsr();
    t_shift_every_cycle();
    t_seed();
    give_verdict();
  end
  // whole run needs well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule // rnc_top_test
bind rnc_top rnc_top_monitor u_rnc_top_monitor (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ringRaw(ringRaw));
